// ---- rtl/bmio_pkg.sv ----
// Constants for the bus-shared byte-wide I/O ports block.
// Assumes a 32-bit AXI4-Lite register bus; word index times four is address.
package bmio_pkg;
   // Register word indexes, byte address is index times four
   localparam logic [5:0] THIRD_DIR_IDX = 6'h10;
   localparam logic [5:0] THIRD_DATA_IDX = 6'h11;
   localparam logic [5:0] FOURTH_DIR_IDX = 6'h12;
   localparam logic [5:0] FOURTH_DATA_IDX = 6'h13;
   localparam logic [5:0] FIFTH_DIR_IDX = 6'h14;
   localparam logic [5:0] FIFTH_DATA_IDX = 6'h15;
   localparam logic [5:0] MODE_IDX = 6'h18;
   // Field layout
   localparam int PORT_W = 8;
   localparam int FIFTH_W = 4;
   localparam int ALE_BIT = 0;
   localparam int OE_BIT = 1;
   localparam int WR_BIT = 2;
   localparam int CAP_BIT = 3;
   // Reset values
   localparam logic [7:0] DIR_RST = 8'hff;
   localparam logic [3:0] FIFTH_DIR_RST = 4'hf;
   localparam logic [7:0] DATA_POR = 8'h00;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Processor modes
   typedef enum logic [1:0] {
      MODE_MICROPROC = 2'h0,
      MODE_EXT_MCU = 2'h1,
      MODE_MCU = 2'h2,
      MODE_PROT_MCU = 2'h3
   } bmio_mode_e;
   localparam logic [1:0] MODE_RST = 2'h2;
   // Handshake states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RESP = 2'b10
   } bmio_st_e;
endpackage

// ---- rtl/bmio_ports.sv ----
// Two byte-wide I/O ports and one four-bit port shared with the multiplexed system bus.
// Assumes pins resolved outside from out and active-low enable; core clock.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps

// Overview of operation
// - Fourth port: eight pins, each input or output
// - Direction one: pin is input, driver off
// - Direction zero: pin drives its latch
// - Data read returns sensed pin levels
// - Data write loads the output latch
// - Bus active: fourth port is high byte
// - Bus only in microprocessor/extended modes
// - Third port bits: I/O or low byte
// - Fifth bit 0: I/O or latch enable
// - Fifth bit 1: I/O or output enable
// - Fifth bit 2: I/O or write strobe
// - Fifth bit 3: I/O or capture input
// - Fifth port upper four bits read zero
// - Direction bits reset to one, all inputs
// - Data latches kept over soft resets
module bmio_ports (
   input wire logic aclk, // Core clock
   input wire logic aresetn, // Power-on/brown-out reset
   input wire logic soft_rst, // Master clear or watchdog pulse
   input wire logic [31:0] awaddr, // Write address
   input wire logic awvalid, // Write address valid
   output logic awready, // Write address ready
   input wire logic [31:0] wdata, // Write data
   input wire logic [3:0] wstrb, // Write byte strobes
   input wire logic wvalid, // Write data valid
   output logic wready, // Write data ready
   output logic [1:0] bresp, // Write response
   output logic bvalid, // Write response valid
   input wire logic bready, // Write response ready
   input wire logic [31:0] araddr, // Read address
   input wire logic arvalid, // Read address valid
   output logic arready, // Read address ready
   output logic [31:0] rdata, // Read data
   output logic [1:0] rresp, // Read response
   output logic rvalid, // Read data valid
   input wire logic rready, // Read data ready
   input wire logic [15:0] bus_ad_out, // Bus address/data to drive
   input wire logic bus_ad_drive, // Bus drives address/data pins
   input wire logic bus_ale, // Bus latch enable strobe
   input wire logic bus_oe_n, // Bus output enable, low active
   input wire logic bus_wr, // Bus write strobe
   output logic [15:0] bus_ad_in, // Sensed address/data pins
   output logic bus_active, // Pins serve the system bus
   output logic capture_four_input, // Capture unit input level
   input wire logic [bmio_pkg::PORT_W-1:0] third_pin_in, // Pin levels
   output logic [bmio_pkg::PORT_W-1:0] third_pin_out, // Pin drive
   output logic [bmio_pkg::PORT_W-1:0] third_pin_oe_n, // Low drives
   input wire logic [bmio_pkg::PORT_W-1:0] fourth_pin_in, // Pin levels
   output logic [bmio_pkg::PORT_W-1:0] fourth_pin_out, // Pin drive
   output logic [bmio_pkg::PORT_W-1:0] fourth_pin_oe_n, // Low drives
   input wire logic [bmio_pkg::FIFTH_W-1:0] fifth_pin_in, // Pin levels
   output logic [bmio_pkg::FIFTH_W-1:0] fifth_pin_out, // Pin drive
   output logic [bmio_pkg::FIFTH_W-1:0] fifth_pin_oe_n // Low drives
);
   import bmio_pkg::*;

   localparam int SYNC_W = 2 * PORT_W + FIFTH_W;

   logic [7:0] third_direction_reg;
   logic [7:0] third_data_reg;
   logic [7:0] fourth_direction_reg;
   logic [7:0] fourth_data_reg;
   logic [3:0] fifth_direction_reg;
   logic [3:0] fifth_data_reg;
   bmio_mode_e mode_reg;
   logic [SYNC_W-1:0] sync1_reg;
   logic [SYNC_W-1:0] sync2_reg;
   logic [7:0] third_level;
   logic [7:0] fourth_level;
   logic [3:0] fifth_level;
   logic bus_sel;
   bmio_st_e wr_st_reg;
   bmio_st_e rd_st_reg;
   logic aw_got_reg;
   logic w_got_reg;
   logic [5:0] wr_idx_reg;
   logic [31:0] wr_data_reg;
   logic wr_byte_reg;
   logic aw_hs;
   logic w_hs;
   logic wr_do;
   logic [31:0] rd_word;
   logic rd_hit;
   logic wr_hit;
   logic [5:0] wr_idx;
   logic [31:0] wr_d;
   logic wr_en;

   // Two-flop synchroniser for all pin inputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= {fifth_pin_in, fourth_pin_in, third_pin_in};
         sync2_reg <= sync1_reg;
      end
   end

   assign third_level = sync2_reg[PORT_W-1:0];
   assign fourth_level = sync2_reg[2*PORT_W-1:PORT_W];
   assign fifth_level = sync2_reg[SYNC_W-1:2*PORT_W];

   // Bus owns the pins only in the two external modes
   assign bus_sel = (mode_reg == MODE_MICROPROC) ||
                    (mode_reg == MODE_EXT_MCU);

   // Write channel handshakes
   assign aw_hs = awvalid && awready;
   assign w_hs = wvalid && wready;
   assign wr_do = (wr_st_reg == ST_IDLE) && (aw_got_reg || aw_hs) &&
                  (w_got_reg || w_hs);

   // Write side handshake state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_st_reg <= ST_IDLE;
         aw_got_reg <= 1'b0;
         w_got_reg <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         wr_idx_reg <= '0;
         wr_data_reg <= '0;
         wr_byte_reg <= 1'b0;
      end else begin
         unique case (wr_st_reg)
            ST_IDLE: begin
               if (aw_hs) begin
                  wr_idx_reg <= awaddr[7:2];
               end
               if (w_hs) begin
                  wr_data_reg <= wdata;
                  wr_byte_reg <= wstrb[0];
               end
               if (wr_do) begin
                  wr_st_reg <= ST_RESP;
                  bvalid <= 1'b1;
                  bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                  awready <= 1'b0;
                  wready <= 1'b0;
                  aw_got_reg <= 1'b0;
                  w_got_reg <= 1'b0;
               end else begin
                  aw_got_reg <= aw_got_reg || aw_hs;
                  w_got_reg <= w_got_reg || w_hs;
                  awready <= !(aw_got_reg || aw_hs);
                  wready <= !(w_got_reg || w_hs);
               end
            end
            ST_RESP: begin
               if (bready) begin
                  wr_st_reg <= ST_IDLE;
                  bvalid <= 1'b0;
                  awready <= 1'b1;
                  wready <= 1'b1;
               end
            end
         endcase
      end
   end

   // Pending write, either channel may have been taken earlier
   assign wr_idx = aw_got_reg ? wr_idx_reg : awaddr[7:2];
   assign wr_d = w_got_reg ? wr_data_reg : wdata;
   assign wr_en = wr_do && (w_got_reg ? wr_byte_reg : wstrb[0]);

   // Address check on the pending write
   always_comb begin
      wr_hit = 1'b0;
      if (wr_idx == THIRD_DIR_IDX || wr_idx == THIRD_DATA_IDX ||
          wr_idx == FOURTH_DIR_IDX || wr_idx == FOURTH_DATA_IDX ||
          wr_idx == FIFTH_DIR_IDX || wr_idx == FIFTH_DATA_IDX ||
          wr_idx == MODE_IDX) begin
         wr_hit = 1'b1;
      end
   end

   // Direction writes; any reset returns every direction bit to input
   always_ff @(posedge aclk) begin
      if (!aresetn || soft_rst) begin
         third_direction_reg <= DIR_RST;
         fourth_direction_reg <= DIR_RST;
         fifth_direction_reg <= FIFTH_DIR_RST;
      end else if (wr_en) begin
         if (wr_idx == THIRD_DIR_IDX) third_direction_reg <= wr_d[7:0];
         if (wr_idx == FOURTH_DIR_IDX) begin
            fourth_direction_reg <= wr_d[7:0];
         end
         if (wr_idx == FIFTH_DIR_IDX) fifth_direction_reg <= wr_d[3:0];
      end
   end

   // Processor mode, kept over soft reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_reg <= bmio_mode_e'(MODE_RST);
      end else if (wr_en && wr_idx == MODE_IDX) begin
         mode_reg <= bmio_mode_e'(wr_d[1:0]);
      end
   end

   // Latches clear to DATA_POR on power-on reset; kept over soft reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         third_data_reg <= DATA_POR;
         fourth_data_reg <= DATA_POR;
         fifth_data_reg <= DATA_POR[3:0];
      end else if (wr_en) begin
         if (wr_idx == THIRD_DATA_IDX) third_data_reg <= wr_d[7:0];
         if (wr_idx == FOURTH_DATA_IDX) fourth_data_reg <= wr_d[7:0];
         if (wr_idx == FIFTH_DATA_IDX) fifth_data_reg <= wr_d[3:0];
      end
   end

   // Read mux; data registers show sensed pin levels
   always_comb begin
      rd_word = '0;
      rd_hit = 1'b1;
      unique case (araddr[7:2])
         THIRD_DIR_IDX: rd_word[7:0] = third_direction_reg;
         THIRD_DATA_IDX: rd_word[7:0] = third_level;
         FOURTH_DIR_IDX: rd_word[7:0] = fourth_direction_reg;
         FOURTH_DATA_IDX: rd_word[7:0] = fourth_level;
         FIFTH_DIR_IDX: rd_word[3:0] = fifth_direction_reg;
         FIFTH_DATA_IDX: rd_word[3:0] = fifth_level;
         MODE_IDX: rd_word[1:0] = mode_reg;
         default: rd_hit = 1'b0;
      endcase
   end

   // Read side handshake state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_st_reg <= ST_IDLE;
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else begin
         unique case (rd_st_reg)
            ST_IDLE: begin
               if (arvalid && arready) begin
                  rd_st_reg <= ST_RESP;
                  arready <= 1'b0;
                  rvalid <= 1'b1;
                  rdata <= rd_word;
                  rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
               end else begin
                  arready <= 1'b1;
               end
            end
            ST_RESP: begin
               if (rready) begin
                  rd_st_reg <= ST_IDLE;
                  rvalid <= 1'b0;
                  arready <= 1'b1;
               end
            end
         endcase
      end
   end

   // Pin drivers: bus override or latch and direction
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         third_pin_out <= '0;
         fourth_pin_out <= '0;
         fifth_pin_out <= '0;
         third_pin_oe_n <= '1;
         fourth_pin_oe_n <= '1;
         fifth_pin_oe_n <= '1;
      end else if (bus_sel) begin
         third_pin_out <= bus_ad_out[7:0];
         fourth_pin_out <= bus_ad_out[15:8];
         third_pin_oe_n <= {PORT_W{!bus_ad_drive}};
         fourth_pin_oe_n <= {PORT_W{!bus_ad_drive}};
         fifth_pin_out[ALE_BIT] <= bus_ale;
         fifth_pin_out[OE_BIT] <= bus_oe_n;
         fifth_pin_out[WR_BIT] <= bus_wr;
         fifth_pin_oe_n[WR_BIT:ALE_BIT] <= 3'h0;
         fifth_pin_out[CAP_BIT] <= fifth_data_reg[CAP_BIT];
         fifth_pin_oe_n[CAP_BIT] <= fifth_direction_reg[CAP_BIT];
      end else begin
         third_pin_out <= third_data_reg;
         fourth_pin_out <= fourth_data_reg;
         fifth_pin_out <= fifth_data_reg;
         third_pin_oe_n <= third_direction_reg;
         fourth_pin_oe_n <= fourth_direction_reg;
         fifth_pin_oe_n <= fifth_direction_reg;
      end
   end

   // Sensed values toward bus logic and capture unit
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_ad_in <= '0;
         bus_active <= 1'b0;
         capture_four_input <= 1'b0;
      end else begin
         bus_ad_in <= {fourth_level, third_level};
         bus_active <= bus_sel;
         capture_four_input <= fifth_level[CAP_BIT];
      end
   end

   // Checks next to the logic they guard
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_dir_soft_reset: assert property (
      soft_rst |=> third_direction_reg == DIR_RST &&
      fourth_direction_reg == DIR_RST &&
      fifth_direction_reg == FIFTH_DIR_RST)
      else $error("direction not input after soft reset");
   a_latch_kept: assert property (
      soft_rst && !wr_do |=> $stable(fourth_data_reg))
      else $error("latch lost on soft reset");
   a_input_off: assert property (
      !bus_sel && fourth_direction_reg[0] |=> fourth_pin_oe_n[0])
      else $error("input pin is driven");
   a_output_drive: assert property (
      !bus_sel && !third_direction_reg[2] |=>
      !third_pin_oe_n[2] && third_pin_out[2] == $past(third_data_reg[2]))
      else $error("output pin not driving latch");
   a_read_pins: assert property (
      rd_st_reg == ST_IDLE && arvalid && arready &&
      araddr[7:2] == FOURTH_DATA_IDX |=>
      rdata[7:0] == $past(fourth_pin_in, 3))
      else $error("read does not return pin level");
   a_bus_high: assert property (
      bus_sel |=> fourth_pin_out == $past(bus_ad_out[15:8]))
      else $error("high byte not on fourth port");
   a_bus_mode: assert property (
      mode_reg == MODE_MCU |=> !bus_active)
      else $error("bus active in plain mode");
   a_strobes: assert property (
      bus_sel |=> fifth_pin_out[OE_BIT] == $past(bus_oe_n) &&
      fifth_pin_out[ALE_BIT] == $past(bus_ale) &&
      fifth_pin_out[WR_BIT] == $past(bus_wr) &&
      fifth_pin_oe_n[WR_BIT:ALE_BIT] == 3'h0)
      else $error("bus strobes not on fifth port");
   a_upper_zero: assert property (
      rd_st_reg == ST_IDLE && arvalid && arready &&
      (araddr[7:2] == FIFTH_DIR_IDX || araddr[7:2] == FIFTH_DATA_IDX)
      |=> rdata[31:4] == 28'h0)
      else $error("unimplemented bits read nonzero");
   a_write_resp: assert property (
      wr_do |=> bvalid ##0 $past(wr_hit) ==
      (bresp == RESP_OKAY))
      else $error("write response mismatch");

   c_bus_mode: cover property (bus_sel && bus_ad_drive && bus_ale);
   c_write_done: cover property (bvalid && bready);
   c_read_done: cover property (rvalid && rready && rresp == RESP_OKAY);
   c_soft_reset: cover property (soft_rst && fourth_data_reg != 8'h00);
endmodule

// ---- dv/bmio_ext_model.sv ----
// Board-side model: pin resolution plus an external address latch.
// Assumes weak pull-ups on every port pin; pins packed {fifth,fourth,third}.
`timescale 1ns/1ps
module bmio_ext_model (
   input wire logic aclk, // Core clock
   input wire logic [19:0] pin_out, // Device drive values
   input wire logic [19:0] pin_oe_n, // Device enables, low drives
   input wire logic [19:0] ext_val, // Far-side drive values
   input wire logic [19:0] ext_en, // Far-side drive enables
   output logic [19:0] pin_lvl, // Resolved pin levels
   output logic [15:0] addr_latch // Address captured while ALE high
);
   // Device wins, then far side, else pull-up holds the line high
   assign pin_lvl = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val)
      | (pin_oe_n & ~ext_en);
   // External latch loads the address pins on each clock edge while the ALE pin is high
   always_ff @(posedge aclk) begin
      if (pin_lvl[16]) begin
         addr_latch <= pin_lvl[15:0];
      end
   end
endmodule

// ---- dv/tb.sv ----
// Register-level bench for the bus-shared I/O ports over AXI4-Lite.
// Assumes the board model resolves pins; one 200 MHz clock.
`timescale 1ns/1ps
module tb;
   import bmio_pkg::*;
   logic aclk, aresetn, soft_rst;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [15:0] bus_ad_out, bus_ad_in, addr_latch;
   logic bus_ad_drive, bus_ale, bus_oe_n, bus_wr, bus_active, cap_in;
   logic [7:0] t_out, t_oe_n, f_out, f_oe_n;
   logic [3:0] e_out, e_oe_n;
   logic [19:0] pin_lvl, ext_val, ext_en;
   int miscompares, n_tests;
   bmio_ports dut_u (.aclk(aclk), .aresetn(aresetn), .soft_rst(soft_rst),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .bus_ad_out(bus_ad_out), .bus_ad_drive(bus_ad_drive),
      .bus_ale(bus_ale), .bus_oe_n(bus_oe_n), .bus_wr(bus_wr),
      .bus_ad_in(bus_ad_in), .bus_active(bus_active),
      .capture_four_input(cap_in), .third_pin_in(pin_lvl[7:0]),
      .third_pin_out(t_out), .third_pin_oe_n(t_oe_n),
      .fourth_pin_in(pin_lvl[15:8]), .fourth_pin_out(f_out),
      .fourth_pin_oe_n(f_oe_n), .fifth_pin_in(pin_lvl[19:16]),
      .fifth_pin_out(e_out), .fifth_pin_oe_n(e_oe_n));
   bmio_ext_model ext_u (.aclk(aclk), .pin_out({e_out, f_out, t_out}),
      .pin_oe_n({e_oe_n, f_oe_n, t_oe_n}), .ext_val(ext_val),
      .ext_en(ext_en), .pin_lvl(pin_lvl), .addr_latch(addr_latch));
   // Clock generation
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // Byte address from a register word index
   function automatic logic [31:0] ad(input logic [5:0] i);
      return {24'h0, i, 2'b00};
   endfunction
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // AXI4-Lite write with response check
   task automatic axw(input logic [31:0] a, input logic [31:0] d,
         input logic [1:0] er);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   // AXI4-Lite read with data and response check
   task automatic axr(input logic [31:0] a, input logic [31:0] ed,
         input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
   endtask
   // Verdict and end of run
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Hang guard, far beyond the expected run of under two hundred cycles
   initial begin
      repeat (20000) @(posedge aclk);
      miscompares++;
      complete_run;
   end
   // Main sequence
   initial begin
      {aresetn, soft_rst, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, wdata, araddr, bus_ad_out, ext_val, ext_en} = '0;
      {bus_ad_drive, bus_ale, bus_wr} = '0;
      bus_oe_n = 1'b1;
      wstrb = 4'hf;
      miscompares = 0;
      n_tests = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      axr(ad(THIRD_DIR_IDX), 32'hff, RESP_OKAY);
      axr(ad(FOURTH_DIR_IDX), 32'hff, RESP_OKAY);
      axr(ad(FIFTH_DIR_IDX), 32'h0f, RESP_OKAY);
      axr(ad(MODE_IDX), 32'h2, RESP_OKAY);
      axw(ad(6'h1f), 32'h5a, RESP_SLVERR);
      axr(ad(6'h1f), 32'h0, RESP_SLVERR);
      // Third port split: low nibble out, high nibble sensed
      ext_val[7:4] <= 4'h9;
      ext_en[7:4] <= 4'hf;
      axw(ad(THIRD_DATA_IDX), 32'h3c, RESP_OKAY);
      axw(ad(THIRD_DIR_IDX), 32'hf0, RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk({24'h0, t_oe_n}, 32'hf0);
      chk({28'h0, t_out[3:0]}, 32'hc);
      axr(ad(THIRD_DATA_IDX), 32'h9c, RESP_OKAY);
      // Fourth port all outputs
      axw(ad(FOURTH_DATA_IDX), 32'h55, RESP_OKAY);
      axw(ad(FOURTH_DIR_IDX), 32'h00, RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk({16'h0, f_oe_n, f_out}, 32'h0055);
      axr(ad(FOURTH_DATA_IDX), 32'h55, RESP_OKAY);
      // Byte 0 strobe low: accepted, latch untouched
      wstrb <= 4'he;
      axw(ad(FOURTH_DATA_IDX), 32'h00, RESP_OKAY);
      wstrb <= 4'hf;
      repeat (2) @(posedge aclk);
      chk({24'h0, f_out}, 32'h55);
      // Fifth port upper bits absent
      axw(ad(FIFTH_DATA_IDX), 32'hff, RESP_OKAY);
      axr(ad(FIFTH_DATA_IDX), 32'h0f, RESP_OKAY);
      axw(ad(FIFTH_DIR_IDX), 32'hff, RESP_OKAY);
      axr(ad(FIFTH_DIR_IDX), 32'h0f, RESP_OKAY);
      axw(ad(FIFTH_DATA_IDX), 32'h0a, RESP_OKAY);
      axw(ad(FIFTH_DIR_IDX), 32'h00, RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk({24'h0, e_oe_n, e_out}, 32'h0a);
      // Soft reset: directions back to input, latches kept
      soft_rst <= 1'b1;
      @(posedge aclk);
      soft_rst <= 1'b0;
      repeat (3) @(posedge aclk);
      chk({24'h0, f_oe_n}, 32'hff);
      axr(ad(FOURTH_DIR_IDX), 32'hff, RESP_OKAY);
      axw(ad(FOURTH_DIR_IDX), 32'h00, RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk({24'h0, f_out}, 32'h55);
      // Every processor mode, ending in microprocessor
      for (int m = 3; m >= 0; m--) begin
         axw(ad(MODE_IDX), 32'(m), RESP_OKAY);
         repeat (3) @(posedge aclk);
         chk({31'h0, bus_active}, 32'(m < 2));
      end
      // Bus owns the pins: address out with strobes
      bus_ad_out <= 16'ha5c3;
      bus_ad_drive <= 1'b1;
      bus_ale <= 1'b1;
      bus_oe_n <= 1'b0;
      bus_wr <= 1'b1;
      repeat (3) @(posedge aclk);
      chk({16'h0, f_out, t_out}, 32'ha5c3);
      chk({16'h0, f_oe_n, t_oe_n}, 32'h0);
      chk({28'h0, e_oe_n[3], e_out[2:0]}, 32'hd);
      chk({29'h0, e_oe_n[2:0]}, 32'h0);
      bus_ale <= 1'b0;
      repeat (3) @(posedge aclk);
      chk({16'h0, addr_latch}, 32'ha5c3);
      // Bus reads the pins; capture input follows fifth bit 3
      bus_ad_drive <= 1'b0;
      ext_val <= 20'h01234;
      ext_en <= 20'hfffff;
      repeat (5) @(posedge aclk);
      chk({16'h0, bus_ad_in}, 32'h1234);
      chk({31'h0, cap_in}, 32'h0);
      ext_val <= 20'h81234;
      repeat (5) @(posedge aclk);
      chk({31'h0, cap_in}, 32'h1);
      complete_run;
   end
endmodule
